// >>> rtl/pabias_pkg.sv
// shared constants and types for the bias register bank
package pabias_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BIAS_COUNT = 6;
    // register addresses
    localparam logic [4:0] ADDR_SYSTEM_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_CARRIER_SENSE_LEVEL = 5'h01;
    localparam logic [4:0] ADDR_CARRIER_DRIVER_GATE_LEVEL = 5'h02;
    localparam logic [4:0] ADDR_CARRIER_FINAL_GATE_LEVEL = 5'h03;
    localparam logic [4:0] ADDR_PEAKING_SENSE_LEVEL = 5'h04;
    localparam logic [4:0] ADDR_PEAKING_DRIVER_GATE_LEVEL = 5'h05;
    localparam logic [4:0] ADDR_PEAKING_FINAL_GATE_LEVEL = 5'h06;
    localparam logic [4:0] ADDR_TEMPERATURE_READING = 5'h0f;
    localparam logic [4:0] ADDR_OVERRIDE_UNLOCK_KEY = 5'h11;
    // system control fields
    localparam int unsigned SOFT_RESET_BIT = 6;
    localparam int unsigned OTP_REFRESH_BIT = 5;
    localparam int unsigned REVISION_MSB = 3;
    localparam logic SOFT_RESET_RESET = 1'b0;
    localparam logic OTP_REFRESH_RESET = 1'b0;
    // bias level fields and values
    localparam logic [7:0] SENSE_LEVEL_MASK = 8'h3f;
    localparam logic [7:0] GATE_LEVEL_MASK = 8'hff;
    localparam logic [7:0] SENSE_LEVEL_RESET = 8'h20;
    localparam logic [7:0] GATE_LEVEL_RESET = 8'h80;
    localparam logic [7:0] OVERRIDE_UNLOCK_VALUE = 8'he3;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // otp copy sequence: one read cycle, then one write per bias register
    localparam logic [2:0] LOAD_COUNT_FIRST = 3'h0;
    localparam logic [2:0] LOAD_COUNT_LAST = 3'h6;
    localparam int unsigned LOAD_CYCLES = 7;

    typedef enum logic [1:0] {
        PABIAS_LOAD_IDLE = 2'b01,
        PABIAS_LOAD_RUN = 2'b10
    } pabias_load_type;

    // bias index 0 and 3 are the sense levels, the rest are gate levels
    function automatic logic [7:0] pabias_mask(input logic [2:0] idx);
        pabias_mask = (idx == 3'h0 || idx == 3'h3) ? SENSE_LEVEL_MASK : GATE_LEVEL_MASK;
    endfunction : pabias_mask

    function automatic logic [7:0] pabias_reset(input logic [2:0] idx);
        pabias_reset = (idx == 3'h0 || idx == 3'h3) ? SENSE_LEVEL_RESET : GATE_LEVEL_RESET;
    endfunction : pabias_reset
endpackage : pabias_pkg

// >>> rtl/pabias_otp_rom.sv
// factory bias image: read only, registered read data
`timescale 1ns/10ps
module pabias_otp_rom
    import pabias_pkg::*;
#(
    parameter logic [47:0] OTP_IMAGE = {GATE_LEVEL_RESET, GATE_LEVEL_RESET, SENSE_LEVEL_RESET,
                                        GATE_LEVEL_RESET, GATE_LEVEL_RESET, SENSE_LEVEL_RESET}
) (
    // clock
    input wire logic clk,
    // read port
    input wire logic [2:0] rd_index,
    output logic [7:0] rd_data
);
    // no write path exists: contents are fixed at build time
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;

    always_comb begin
        case (rd_index)
            3'h0: rd_data_d = OTP_IMAGE[7:0];
            3'h1: rd_data_d = OTP_IMAGE[15:8];
            3'h2: rd_data_d = OTP_IMAGE[23:16];
            3'h3: rd_data_d = OTP_IMAGE[31:24];
            3'h4: rd_data_d = OTP_IMAGE[39:32];
            3'h5: rd_data_d = OTP_IMAGE[47:40];
            default: rd_data_d = READ_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        rd_data_q <= rd_data_d;
    end

    assign rd_data = rd_data_q;
endmodule : pabias_otp_rom

// >>> rtl/pabias_regbank.sv
// bias controller register bank with otp shadow copy and override unlock
//
// Overview of operation
// - power-on and every reset copy factory otp values into the bias registers.
// - override-mode bias writes vanish at reset; factory values return.
// - no user path exists to change otp contents.
// - nine user registers, each eight bits wide.
// - address 0 holds soft reset and otp refresh control bits.
// - address 0 low four bits return read-only chip revision.
// - addresses 1 to 6 hold bias levels, loaded from otp.
// - address 15 returns temperature reading; writes do nothing.
// - writing 0xe3 to address 17 enters override mode.
// - in override mode host writes replace otp-loaded bias values.
// - soft reset bit set restores defaults; host writes 0 afterwards.
// - otp refresh bit set reloads otp values; host writes 0 afterwards.
// - sense levels hold six bits; upper two bits read zero.
// - gate levels hold full eight bits, 0x00 minimum to 0xff maximum.
`timescale 1ns/10ps
module pabias_regbank
    import pabias_pkg::*;
#(
    parameter logic [3:0] CHIP_REVISION = 4'h5, // arbitrary value
    parameter logic [47:0] OTP_IMAGE = {GATE_LEVEL_RESET, GATE_LEVEL_RESET, SENSE_LEVEL_RESET,
                                        GATE_LEVEL_RESET, GATE_LEVEL_RESET, SENSE_LEVEL_RESET}
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register access port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [4:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // temperature sensor result, asynchronous to clk
    input wire logic [7:0] temperature_reading,
    // bias levels to the dacs
    output logic [7:0] carrier_sense_level,
    output logic [7:0] carrier_driver_gate_level,
    output logic [7:0] carrier_final_gate_level,
    output logic [7:0] peaking_sense_level,
    output logic [7:0] peaking_driver_gate_level,
    output logic [7:0] peaking_final_gate_level,
    // status
    output logic override_mode,
    output logic load_busy
);
    logic [7:0] bias_q [0:5];
    logic soft_reset_q;
    logic otp_refresh_q;
    logic override_mode_q;
    pabias_load_type load_state_q;
    logic [2:0] load_count_q;
    logic [7:0] temp_sync1_q;
    logic [7:0] temp_sync2_q;
    logic [7:0] temp_sync3_q;
    logic [7:0] temp_stable_q;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic rd_valid_q;
    logic [7:0] otp_data;

    // decode
    wire write_system = wr_en && (addr == ADDR_SYSTEM_CONTROL);
    wire soft_reset_req = write_system && wr_data[SOFT_RESET_BIT];
    wire otp_refresh_req = write_system && wr_data[OTP_REFRESH_BIT];
    wire restore_all = srst || soft_reset_req;
    wire start_load = restore_all || otp_refresh_req;
    wire loading = (load_state_q == PABIAS_LOAD_RUN);
    wire bias_addr = (addr >= ADDR_CARRIER_SENSE_LEVEL) && (addr <= ADDR_PEAKING_FINAL_GATE_LEVEL);
    wire [2:0] host_index = 3'(addr - ADDR_CARRIER_SENSE_LEVEL);
    // a host write racing the otp copy could be overwritten by it, so drop it
    wire host_bias_wr = wr_en && bias_addr && override_mode_q && !loading;
    wire load_wr = loading && (load_count_q != LOAD_COUNT_FIRST);
    wire [2:0] load_index = 3'(load_count_q - 3'h1);
    wire unlock_hit = wr_en && (addr == ADDR_OVERRIDE_UNLOCK_KEY)
                      && (wr_data == OVERRIDE_UNLOCK_VALUE);

    pabias_otp_rom #(
        .OTP_IMAGE(OTP_IMAGE)
    ) u_otp (
        .clk(clk),
        .rd_index(load_count_q),
        .rd_data(otp_data)
    );

    // bias registers: reset value, then otp copy, then host write
    always_ff @(posedge clk) begin
        for (int i = 0; i < BIAS_COUNT; i++) begin
            if (restore_all) begin
                bias_q[i] <= pabias_reset(3'(i));
            end else if (load_wr && load_index == 3'(i)) begin
                bias_q[i] <= otp_data & pabias_mask(3'(i));
            end else if (host_bias_wr && host_index == 3'(i)) begin
                bias_q[i] <= wr_data & pabias_mask(3'(i));
            end
        end
    end

    // otp copy sequencer; any reset or refresh restarts it from the top
    always_ff @(posedge clk) begin
        if (start_load) begin
            load_state_q <= PABIAS_LOAD_RUN;
            load_count_q <= LOAD_COUNT_FIRST;
        end else begin
            case (load_state_q)
                PABIAS_LOAD_RUN: begin
                    if (load_count_q == LOAD_COUNT_LAST) begin
                        load_state_q <= PABIAS_LOAD_IDLE;
                    end
                    load_count_q <= load_count_q + 3'h1;
                end
                PABIAS_LOAD_IDLE: load_count_q <= LOAD_COUNT_FIRST;
                default: begin
                    load_state_q <= PABIAS_LOAD_IDLE;
                    load_count_q <= LOAD_COUNT_FIRST;
                end
            endcase
        end
    end

    // control bits hold what the host wrote until it writes 0
    always_ff @(posedge clk) begin
        if (srst) begin
            soft_reset_q <= SOFT_RESET_RESET;
            otp_refresh_q <= OTP_REFRESH_RESET;
        end else if (write_system) begin
            soft_reset_q <= wr_data[SOFT_RESET_BIT];
            otp_refresh_q <= wr_data[OTP_REFRESH_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (restore_all) begin
            override_mode_q <= 1'b0;
        end else if (unlock_hit) begin
            override_mode_q <= 1'b1;
        end
    end

    // two stages per bit, then a word is taken only once it has held for a cycle,
    // so a code caught mid-change never reaches the host; costs two cycles of latency
    always_ff @(posedge clk) begin
        temp_sync1_q <= temperature_reading;
        temp_sync2_q <= temp_sync1_q;
        temp_sync3_q <= temp_sync2_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            temp_stable_q <= READ_ZERO;
        end else if (temp_sync2_q == temp_sync3_q) begin
            temp_stable_q <= temp_sync3_q;
        end
    end

    // read mux; unlock key and reserved addresses read zero
    always_comb begin
        case (addr)
            ADDR_SYSTEM_CONTROL: rd_data_d = {1'b0, soft_reset_q, otp_refresh_q, 1'b0,
                                              CHIP_REVISION};
            ADDR_CARRIER_SENSE_LEVEL: rd_data_d = bias_q[0];
            ADDR_CARRIER_DRIVER_GATE_LEVEL: rd_data_d = bias_q[1];
            ADDR_CARRIER_FINAL_GATE_LEVEL: rd_data_d = bias_q[2];
            ADDR_PEAKING_SENSE_LEVEL: rd_data_d = bias_q[3];
            ADDR_PEAKING_DRIVER_GATE_LEVEL: rd_data_d = bias_q[4];
            ADDR_PEAKING_FINAL_GATE_LEVEL: rd_data_d = bias_q[5];
            ADDR_TEMPERATURE_READING: rd_data_d = temp_stable_q;
            default: rd_data_d = READ_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_q <= READ_ZERO;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q <= rd_en ? rd_data_d : rd_data_q;
            rd_valid_q <= rd_en;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign carrier_sense_level = bias_q[0];
    assign carrier_driver_gate_level = bias_q[1];
    assign carrier_final_gate_level = bias_q[2];
    assign peaking_sense_level = bias_q[3];
    assign peaking_driver_gate_level = bias_q[4];
    assign peaking_final_gate_level = bias_q[5];
    assign override_mode = override_mode_q;
    assign load_busy = loading;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_quiet;
        !srst && !soft_reset_req && !otp_refresh_req;
    endsequence

    property p_load_ends;
        (loading && load_count_q == LOAD_COUNT_LAST && !start_load) |=> !load_busy;
    endproperty
    a_load_ends: assert property (p_load_ends) else $error("otp copy did not end");

    property p_refresh_runs;
        (otp_refresh_req && !restore_all) ##1 s_quiet [*7] |-> load_busy ##1 !load_busy;
    endproperty
    a_refresh_runs: assert property (p_refresh_runs) else $error("refresh copy length wrong");

    property p_copy_sense;
        (load_wr && load_index == 3'h0 && !restore_all)
            |=> carrier_sense_level == ($past(otp_data) & SENSE_LEVEL_MASK);
    endproperty
    a_copy_sense: assert property (p_copy_sense) else $error("sense copy wrong");

    property p_soft_clears;
        soft_reset_req |=> !override_mode && load_busy
                           && carrier_driver_gate_level == GATE_LEVEL_RESET;
    endproperty
    a_soft_clears: assert property (p_soft_clears) else $error("soft reset incomplete");

    property p_unlock;
        (unlock_hit && !soft_reset_req) |=> override_mode;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock key ignored");

    property p_locked_write;
        (wr_en && addr == ADDR_CARRIER_DRIVER_GATE_LEVEL && !override_mode_q && !start_load
         && !loading) |=> $stable(carrier_driver_gate_level);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked write took effect");

    property p_override_write;
        (host_bias_wr && addr == ADDR_PEAKING_FINAL_GATE_LEVEL && !start_load)
            |=> peaking_final_gate_level == $past(wr_data);
    endproperty
    a_override_write: assert property (p_override_write) else $error("override write lost");

    property p_revision;
        (rd_en && addr == ADDR_SYSTEM_CONTROL) |=> rd_valid && rd_data[REVISION_MSB:0] == CHIP_REVISION
                                                   && rd_data[7] == 1'b0;
    endproperty
    a_revision: assert property (p_revision) else $error("revision field wrong");

    property p_temperature;
        (rd_en && addr == ADDR_TEMPERATURE_READING) |=> rd_data == $past(temp_stable_q);
    endproperty
    a_temperature: assert property (p_temperature) else $error("temperature read wrong");

    property p_reserved;
        (rd_en && (addr == 5'h10 || (addr > ADDR_PEAKING_FINAL_GATE_LEVEL
                                     && addr < ADDR_TEMPERATURE_READING))) |=> rd_data == READ_ZERO;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved address not zero");

    property p_sense_upper;
        (rd_en && addr == ADDR_PEAKING_SENSE_LEVEL) |=> rd_data[7:6] == 2'b00;
    endproperty
    a_sense_upper: assert property (p_sense_upper) else $error("sense upper bits set");
endmodule : pabias_regbank

// >>> sim/pabias_host.sv
// host model that drives the register access port of the bias bank
`timescale 1ns/10ps
module pabias_host (
    // clock
    input wire logic clk,
    // register access port
    output logic wr_en,
    output logic rd_en,
    output logic [4:0] addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 5'h1f;
        wr_data = 8'h00;
    end

    // an idle bus shows the inverse of the last value, so stale data never passes
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        addr = ~a;
        wr_data = ~d;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
        int i;
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        addr = ~a;
        ok = 1'b0;
        d = 8'hxx;
        for (i = 0; i < 4 && !ok; i++) begin
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d = rd_data;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask : rd
endmodule : pabias_host

// >>> sim/tb_top.sv
// self-checking bench for the bias register bank
`timescale 1ns/10ps
module tb_top;
    import pabias_pkg::*;
    localparam logic [3:0] REV = 4'h9; // arbitrary value
    localparam logic [47:0] OTP = {8'h55, 8'h44, 8'h33, 8'h22, 8'h11, 8'h2a};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] temp = 8'h00;
    logic wr_en, rd_en, rd_valid, override_mode, load_busy;
    logic [4:0] addr;
    logic [7:0] wr_data, rd_data;
    logic [7:0] lvl [6];
    wire logic [47:0] lvl_all;
    int n_errors = 0;
    int samples_checked = 0;

    assign lvl_all = {lvl[5], lvl[4], lvl[3], lvl[2], lvl[1], lvl[0]};
    always #50 clk = ~clk;

    pabias_regbank #(.CHIP_REVISION(REV), .OTP_IMAGE(OTP)) u_pabias_regbank (
        .clk(clk), .srst(srst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .temperature_reading(temp),
        .carrier_sense_level(lvl[0]), .carrier_driver_gate_level(lvl[1]),
        .carrier_final_gate_level(lvl[2]), .peaking_sense_level(lvl[3]),
        .peaking_driver_gate_level(lvl[4]), .peaking_final_gate_level(lvl[5]),
        .override_mode(override_mode), .load_busy(load_busy)
    );

    pabias_host u_pabias_host (
        .clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid)
    );

    task automatic results();
        $display("compared %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_pabias_host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            check({47'h0, ok}, 48'h1);
            results();
        end else begin
            check(d, exp);
        end
    endtask : rd_chk

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        u_pabias_host.wr(a, d);
    endtask : wr

    // the copy must take exactly LOAD_CYCLES cycles; a stuck busy flag ends the run
    task automatic wait_load();
        int i;
        for (i = 0; i < 20 && load_busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        check(48'(i), 48'(LOAD_CYCLES));
        if (load_busy !== 1'b0) begin
            n_errors++;
            results();
        end
    endtask : wait_load

    initial begin
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        wait_load();
        check(lvl_all, OTP);
        rd_chk(ADDR_SYSTEM_CONTROL, {4'h0, REV});
        wr(ADDR_SYSTEM_CONTROL, 8'h8f);
        rd_chk(ADDR_SYSTEM_CONTROL, {4'h0, REV});
        wr(ADDR_CARRIER_DRIVER_GATE_LEVEL, 8'hab);
        check(lvl_all, OTP);
        $display("test otp_load done");
        wr(ADDR_OVERRIDE_UNLOCK_KEY, 8'he2);
        check(override_mode, 1'b0);
        wr(ADDR_OVERRIDE_UNLOCK_KEY, 8'he3);
        check(override_mode, 1'b1);
        rd_chk(ADDR_OVERRIDE_UNLOCK_KEY, 8'h00);
        for (int v = 0; v < 2; v++) begin
            for (int r = 1; r <= 6; r++) wr(r[4:0], v ? 8'h00 : 8'hff);
            for (int r = 0; r < 6; r++) begin
                check(lvl[r], v ? 8'h00 : ((r % 3 == 0) ? 8'h3f : 8'hff));
                rd_chk(5'(r + 1), v ? 8'h00 : ((r % 3 == 0) ? 8'h3f : 8'hff));
            end
        end
        $display("test override done");
        wr(ADDR_SYSTEM_CONTROL, 8'h20);
        wait_load();
        check(lvl_all, OTP);
        check(override_mode, 1'b1);
        rd_chk(ADDR_SYSTEM_CONTROL, {4'h2, REV});
        wr(ADDR_SYSTEM_CONTROL, 8'h00);
        $display("test refresh done");
        temp = 8'h9c;
        for (int r = 7; r <= 16; r++) begin
            if (r != 15) begin
                wr(r[4:0], 8'h5a);
                rd_chk(r[4:0], 8'h00);
            end
        end
        check(lvl_all, OTP);
        wr(ADDR_TEMPERATURE_READING, 8'h00);
        rd_chk(ADDR_TEMPERATURE_READING, 8'h9c);
        $display("test reserved done");
        wr(ADDR_CARRIER_DRIVER_GATE_LEVEL, 8'h77);
        wr(ADDR_SYSTEM_CONTROL, 8'h40);
        check(override_mode, 1'b0);
        wait_load();
        check(lvl_all, OTP);
        rd_chk(ADDR_SYSTEM_CONTROL, {4'h4, REV});
        wr(ADDR_SYSTEM_CONTROL, 8'h00);
        $display("test soft_reset done");
        wr(ADDR_OVERRIDE_UNLOCK_KEY, 8'he3);
        wr(ADDR_CARRIER_DRIVER_GATE_LEVEL, 8'h66);
        check(lvl[1], 8'h66);
        @(posedge clk);
        #1;
        srst = 1'b1;
        @(posedge clk);
        #1;
        srst = 1'b0;
        check(override_mode, 1'b0);
        wait_load();
        check(lvl_all, OTP);
        $display("test hard_reset done");
        results();
    end
endmodule : tb_top
